/* bench/fault_interrupt_and_power_ok_logic_tb.sv */
`timescale 1ns/1ps
`include "fault_irq_regs.svh"
module fault_interrupt_and_power_ok_logic_tb;
    import fault_irq_pkg::*;
    logic ref_clk = '0, arst_n = '0, thermal_warn_raw = '0, thermal_shutdown_raw = '0;
    logic supply_overvoltage_raw = '0, sync_clk_present_raw = '0, load_measure_ready_raw = '0;
    logic external_reset_in = '0, supply_lockout = '0, sw_reset_req = '0, clk_detect_enable = '0;
    logic thermal_warn_mask = '0, gpio_mask = '0, sync_clk_mask = '0, load_ready_mask = '0;
    logic reset_flag_mask = '0, sticky_fault_hold_enable = '0, window_mode_select = '0;
    logic power_ok_polarity = '1, power_ok_open_drain = '0, valid_filter_select = '0;
    logic [3:0] rail_current_limit_raw = '0, rail_below_short_level = '0, rail_enabled = '0;
    logic [3:0] rail_above_undervoltage = '0, rail_below_overvoltage = '1, rail_ramping = '0;
    logic [3:0] rail_current_limit_mask = '0, rail_good_mask = '0, rail_event_summary_flag;
    logic [3:0] rail_current_limit_live, rail_good_live, monitor_fault_source_reg, rail_disable;
    logic [1:0] gpio_in_raw = '0, gpio_in_level;
    logic [18:0] flag_clear_w1c = '0, event_flags, e;
    monitor_sel_t [3:0] rail_monitor_select = '0;
    logic irq_n_out, thermal_warn_live, thermal_shutdown_live, supply_overvoltage_live;
    logic sync_clk_live, all_rails_disable, gpio_force_low, power_ok_output, power_ok_oe_n;
    logic fault_source_read;
    logic [12:0] rows [8] = '{13'h00c0, 13'h014c, 13'h016c, 13'h024d, 13'h044e, 13'h080f,
        13'h082f, 13'h1011};
    int failures = 0, n_compared = 0, cycles = 0;
    fault_interrupt_and_power_ok_logic #(.SC_DEBOUNCE_CYC(20))
        fault_interrupt_and_power_ok_logic_inst (.*);
    power_ok_host power_ok_host_inst (.*);
    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cycles == 5000) begin
        failures++;
        close_out();
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic chk(input string nm, input logic [18:0] x, a);
        n_compared++;
        if (a !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, x, a);
        end
    endtask
    task automatic clr(input logic [18:0] v);
        @(posedge ref_clk);
        flag_clear_w1c <= v;
        @(posedge ref_clk);
        flag_clear_w1c <= '0;
        cyc(3);
    endtask
    task automatic stim(input logic [5:0] v);
        @(posedge ref_clk);
        {load_measure_ready_raw, gpio_in_raw[0], supply_overvoltage_raw, thermal_shutdown_raw,
            thermal_warn_raw, rail_current_limit_raw[0]} <= v;
    endtask
    task automatic close_out;
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'h1;
        cyc(3);
        chk("rst_flags", `FLAG_RST, event_flags);
        chk("rst_irq", 1'h0, irq_n_out);
        clr(`FLAG_RST);
        // Row: event inputs, clear refused while live, masked, flag index
        foreach (rows[i]) begin
            stim(rows[i][12:7]);
            {thermal_warn_mask, gpio_mask, rail_current_limit_mask[0]} <= {3{rows[i][5]}};
            cyc(rows[i][7] ? 1010 : 8);
            e = 19'h1 << rows[i][4:0];
            chk("flag", e, event_flags);
            chk("irq", rows[i][5], irq_n_out);
            chk("warn_live", rows[i][8], thermal_warn_live);
            chk("gpio_low", |rows[i][10:9], gpio_force_low);
            clr(e);
            chk("held", rows[i][6] ? e : '0, event_flags);
            stim('0);
            cyc(8);
            clr('1);
            chk("clear", '0, event_flags);
            chk("idle", 1'h1, irq_n_out);
        end
        @(posedge ref_clk);
        rail_monitor_select[0] <= `SEL_VOLT;
        rail_enabled[0] <= 1'h1;
        cyc(400);
        chk("pok_low", 1'h0, power_ok_output);
        chk("src_set", 1'h1, monitor_fault_source_reg[0]);
        @(posedge ref_clk);
        rail_above_undervoltage[0] <= 1'h1;
        cyc(400);
        chk("pok_high", 1'h1, power_ok_output);
        chk("good_live", 1'h1, rail_good_live[0]);
        chk("summary", 1'h1, rail_event_summary_flag[0]);
        chk("src_read", 1'h0, monitor_fault_source_reg[0]);
        @(posedge ref_clk);
        sw_reset_req <= 1'h1;
        power_ok_open_drain <= 1'h1;
        @(posedge ref_clk);
        sw_reset_req <= 1'h0;
        cyc(3);
        chk("sw_rst", `FLAG_RST, event_flags);
        chk("od_release", 1'h1, power_ok_oe_n);
        chk("od_low", 1'h0, power_ok_output);
        close_out();
    end
endmodule

/* bench/fault_irq_props.sv */
`timescale 1ns/1ps
`include "fault_irq_regs.svh"
module fault_irq_props import fault_irq_pkg::*; (
    input wire logic ref_clk, arst_n, irq_n_out, thermal_warn_mask, thermal_warn_live,
    input wire logic all_rails_disable, gpio_force_low, power_ok_open_drain, power_ok_oe_n,
    input wire logic power_ok_output, power_ok_polarity, sticky_fault_hold_enable,
    input wire logic [`FLAG_W-1:0] event_flags,
    input wire monitor_sel_t [`RAIL_N-1:0] rail_monitor_select
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_irq_release: assert property (event_flags == '0 |=> irq_n_out)
        else $error("irq low, no flag");
    chk_irq_pull: assert property (event_flags[12] && !thermal_warn_mask |=> !irq_n_out)
        else $error("irq not low");
    chk_mask_quiet: assert property (event_flags == 19'h1000 && thermal_warn_mask |=> irq_n_out)
        else $error("masked flag drove irq");
    chk_warn_refuse: assert property (thermal_warn_live && event_flags[12]
        |=> event_flags[12] || event_flags == `FLAG_RST)
        else $error("hot warn cleared");
    chk_tsd_off: assert property ($rose(event_flags[13]) |->
        ##[0:3] (all_rails_disable && gpio_force_low)) else $error("tsd kept rails");
    chk_ov_off: assert property ($rose(event_flags[14]) |->
        ##[0:3] (all_rails_disable && gpio_force_low)) else $error("ov kept rails");
    chk_pushpull_drive: assert property (!power_ok_open_drain |=> !power_ok_oe_n)
        else $error("push-pull undriven");
    chk_unmon_active: assert property ((rail_monitor_select == '0 && !sticky_fault_hold_enable
        && !power_ok_open_drain && event_flags[14:13] == '0)[*3]
        |=> power_ok_output == $past(power_ok_polarity))
        else $error("unmonitored power-ok low");
    cover property (!irq_n_out);
    cover property ($fell(power_ok_output));
    cover property ($rose(event_flags[14]));
endmodule
bind fault_interrupt_and_power_ok_logic fault_irq_props fault_irq_props_inst (.*);

/* bench/power_ok_host.sv */
`timescale 1ns/1ps
// Reads fault source as power-ok turns active
module power_ok_host (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic power_ok_output,
    input  wire logic power_ok_oe_n,
    input  wire logic power_ok_polarity,
    output logic      fault_source_read
);
    logic ok_q;
    logic pin_ok;
    // Released open-drain pin reads as its pull-up
    assign pin_ok = (power_ok_oe_n | power_ok_output) == power_ok_polarity;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ok_q <= 1'h0;
            fault_source_read <= 1'h0;
        end else begin
            ok_q <= pin_ok;
            fault_source_read <= pin_ok && !ok_q;
        end
    end
endmodule

/* rtl/fault_interrupt_and_power_ok_logic.sv */
//
// Contract
// - Any protection or warning event sets its sticky flag and, unless masked, pulls irq low.
// - Irq stays low until every pending unmasked flag is cleared.
// - Whole-device shutdown faults show as the reset flag after next start-up.
// - Current limit held 20 us sets rail flag; clear refused while limiting.
// - Output under 0.35 V for 1 ms disables rail, sets unmaskable flag.
// - Thermal warning sets maskable flag; clear refused while still hot.
// - Thermal shutdown disables all, forces GPIO low, unmaskable flag.
// - Supply overvoltage disables all, forces GPIO low, unmaskable flag.
// - Rail reaching target sets maskable rail good flag with live status.
// - GPIO event and load-measurement-ready each set their own maskable flag.
// - With detector on, sync clock change or absence sets maskable flag.
// - External reset edge, lockout or software reset restore defaults, flag reset.
// - Each rail has a two-bit power-ok monitoring selector.
// - Combined monitoring needs voltage in window and current below limit.
// - A disabled rail forces power-ok inactive only while its short flag or a shutdown flag is pending.
// - A ramping rail reports voltage monitoring inactive.
// - Power-ok active only when all monitored rails are active.
// - Reading fault source clears bits not currently forcing power-ok inactive.
// - Sticky hold option keeps power-ok inactive while fault bits pending.
// - Window bit 0 checks undervoltage only, 1 checks both limits.
// - Power-ok polarity and push-pull or open-drain are separate bits.
// - Invalid voltage filtered 7 us; valid filter time selectable.
// - Selector 00 means unmonitored, contribution always active.
//
`timescale 1ns/1ps
`include "fault_irq_regs.svh"
module fault_interrupt_and_power_ok_logic #(
    parameter int SC_DEBOUNCE_CYC = `SC_DEB_CYC
) (
    input  wire logic                                 ref_clk,
    input  wire logic                                 arst_n,
    // Per-rail analog and control conditions, asynchronous
    input  wire logic [`RAIL_N-1:0]                   rail_current_limit_raw,
    input  wire logic [`RAIL_N-1:0]                   rail_below_short_level,
    input  wire logic [`RAIL_N-1:0]                   rail_above_undervoltage,
    input  wire logic [`RAIL_N-1:0]                   rail_below_overvoltage,
    input  wire logic [`RAIL_N-1:0]                   rail_enabled,
    input  wire logic [`RAIL_N-1:0]                   rail_ramping,
    // Device-level conditions, asynchronous
    input  wire logic                                 thermal_warn_raw,
    input  wire logic                                 thermal_shutdown_raw,
    input  wire logic                                 supply_overvoltage_raw,
    input  wire logic [`GPIO_N-1:0]                   gpio_in_raw,
    input  wire logic                                 sync_clk_present_raw,
    input  wire logic                                 load_measure_ready_raw,
    input  wire logic                                 external_reset_in,
    input  wire logic                                 supply_lockout,
    // Configuration, same clock domain
    input  wire logic                                 sw_reset_req,
    input  wire logic                                 clk_detect_enable,
    input  wire logic [`FLAG_W-1:0]                   flag_clear_w1c,
    input  wire logic [`RAIL_N-1:0]                   rail_current_limit_mask,
    input  wire logic [`RAIL_N-1:0]                   rail_good_mask,
    input  wire logic                                 thermal_warn_mask,
    input  wire logic                                 gpio_mask,
    input  wire logic                                 sync_clk_mask,
    input  wire logic                                 load_ready_mask,
    input  wire logic                                 reset_flag_mask,
    input  fault_irq_pkg::monitor_sel_t [`RAIL_N-1:0] rail_monitor_select,
    input  wire logic                                 sticky_fault_hold_enable,
    input  wire logic                                 window_mode_select,
    input  wire logic                                 power_ok_polarity,
    input  wire logic                                 power_ok_open_drain,
    input  wire logic                                 valid_filter_select,
    input  wire logic                                 fault_source_read,
    // Status and outputs
    output logic                                      irq_n_out,
    output logic      [`FLAG_W-1:0]                   event_flags,
    output logic      [`RAIL_N-1:0]                   rail_event_summary_flag,
    output logic      [`RAIL_N-1:0]                   rail_current_limit_live,
    output logic      [`RAIL_N-1:0]                   rail_good_live,
    output logic                                      thermal_warn_live,
    output logic                                      thermal_shutdown_live,
    output logic                                      supply_overvoltage_live,
    output logic      [`GPIO_N-1:0]                   gpio_in_level,
    output logic                                      sync_clk_live,
    output logic      [`RAIL_N-1:0]                   monitor_fault_source_reg,
    output logic      [`RAIL_N-1:0]                   rail_disable,
    output logic                                      all_rails_disable,
    output logic                                      gpio_force_low,
    output logic                                      power_ok_output,
    output logic                                      power_ok_oe_n
);
    import fault_irq_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic rail_contrib(input monitor_sel_t sel,
                                          input logic         off_fault,
                                          input logic         en,
                                          input logic         ramp,
                                          input logic         volt_ok,
                                          input logic         ilim);
        logic ok;
        if (sel == `SEL_NONE) begin
            ok = 1'b1;
        end else if (off_fault) begin
            ok = 1'b0;
        end else if (!en) begin
            ok = 1'b1;
        end else if (ramp) begin
            ok = 1'b0;
        end else if (sel == `SEL_VOLT) begin
            ok = volt_ok;
        end else begin
            ok = volt_ok & ~ilim;
        end
        return ok;
    endfunction

    main_state_t s_q;
    main_state_t s_d;

    logic [`SYNC_W-1:0] async_in;
    logic [`RAIL_N-1:0] ilim_f;
    logic [`RAIL_N-1:0] sc_f;
    logic [`RAIL_N-1:0] uv_f;
    logic [`RAIL_N-1:0] ov_f;
    logic [`FLAG_W-1:0] flags;
    logic [`FLAG_W-1:0] flag_set;
    logic [`FLAG_W-1:0] flag_block;
    logic [`FLAG_W-1:0] flag_mask;
    logic               soft_rst;
    logic [`CNT_W-1:0]  valid_len;
    logic [`CNT_W-1:0]  sc_len;

    assign async_in = {supply_lockout, external_reset_in, load_measure_ready_raw,
                       sync_clk_present_raw, gpio_in_raw, supply_overvoltage_raw,
                       thermal_shutdown_raw, thermal_warn_raw, rail_ramping, rail_enabled,
                       rail_below_overvoltage, rail_above_undervoltage,
                       rail_below_short_level, rail_current_limit_raw};

    assign valid_len = valid_filter_select ? `PG_VLONG_CYC : `PG_VSHORT_CYC;
    assign sc_len    = SC_DEBOUNCE_CYC[`CNT_W-1:0];

    // ----------------------------------------------------------------
    // Qualification filters
    // ----------------------------------------------------------------
    // One filter covers both the start-up and the in-operation short case,
    // since the count starts with enable and restarts on any recovery.
    for (genvar i = 0; i < `RAIL_N; i++) begin : g_rail
        level_debouncer u_ilim (
            .ref_clk   (ref_clk),
            .arst_n    (arst_n),
            .qual      (1'b1),
            .level_in  (s_q.sync[`S_ILIM + i]),
            .rise_len  (`ILIM_DEB_CYC),
            .fall_len  (`ONE_CYC),
            .level_out (ilim_f[i])
        );
        level_debouncer u_short (
            .ref_clk   (ref_clk),
            .arst_n    (arst_n),
            .qual      (s_q.sync[`S_EN + i] & ~flags[`F_SC + i]),
            .level_in  (s_q.sync[`S_BELOW + i]),
            .rise_len  (sc_len),
            .fall_len  (`ONE_CYC),
            .level_out (sc_f[i])
        );
        level_debouncer u_under (
            .ref_clk   (ref_clk),
            .arst_n    (arst_n),
            .qual      (1'b1),
            .level_in  (s_q.sync[`S_UV + i]),
            .rise_len  (valid_len),
            .fall_len  (`PG_INVALID_CYC),
            .level_out (uv_f[i])
        );
        level_debouncer u_over (
            .ref_clk   (ref_clk),
            .arst_n    (arst_n),
            .qual      (1'b1),
            .level_in  (s_q.sync[`S_OV + i]),
            .rise_len  (valid_len),
            .fall_len  (`PG_INVALID_CYC),
            .level_out (ov_f[i])
        );
    end

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    sticky_flag_bank u_flags (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .soft_rst  (soft_rst),
        .set_evt   (flag_set),
        .clr_w1c   (flag_clear_w1c),
        .clr_block (flag_block),
        .flags     (flags)
    );

    always_comb begin
        logic [`RAIL_N-1:0] volt_ok;
        logic [`RAIL_N-1:0] contrib;
        logic [`RAIL_N-1:0] en;
        logic               pg_active;
        logic               pg_level;
        logic               clk_evt;
        volt_ok   = '0;
        contrib   = '0;
        en        = s_q.sync[`S_EN +: `RAIL_N];
        pg_active = 1'b0;
        pg_level  = 1'b0;
        clk_evt   = 1'b0;
        s_d       = s_q;

        // Two-stage synchroniser; the first stage feeds only the second
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;

        // External reset rising edge, lockout or software request
        soft_rst = (s_q.sync[`S_EXTRST] & ~s_q.prev[`S_EXTRST])
                 | s_q.sync[`S_LOCK] | sw_reset_req;

        // Voltage window per rail
        for (int i = 0; i < `RAIL_N; i++) begin
            volt_ok[i] = uv_f[i] & (~window_mode_select | ov_f[i]);
        end
        s_d.ilim_prev = ilim_f;
        s_d.sc_prev   = sc_f;
        s_d.good_prev = volt_ok & en;

        // Sync clock appears, disappears or is missing
        clk_evt = clk_detect_enable
                & ((s_q.sync[`S_CLKP] ^ s_q.prev[`S_CLKP]) | ~s_q.sync[`S_CLKP]);

        flag_set = '0;
        flag_set[`F_ILIM +: `RAIL_N] = ilim_f & ~s_q.ilim_prev;
        flag_set[`F_SC +: `RAIL_N]   = sc_f & ~s_q.sc_prev;
        flag_set[`F_PG +: `RAIL_N]   = volt_ok & en & ~s_q.good_prev;
        flag_set[`F_TWARN] = s_q.sync[`S_TWARN] & ~s_q.prev[`S_TWARN];
        flag_set[`F_TSD]   = s_q.sync[`S_TSD] & ~s_q.prev[`S_TSD];
        flag_set[`F_OVP]   = s_q.sync[`S_OVP] & ~s_q.prev[`S_OVP];
        flag_set[`F_GPIO]  = |(s_q.sync[`S_GPIO +: `GPIO_N]
                             ^ s_q.prev[`S_GPIO +: `GPIO_N]);
        flag_set[`F_SYNC]  = clk_evt;
        flag_set[`F_ILOAD] = s_q.sync[`S_ILOAD] & ~s_q.prev[`S_ILOAD];

        flag_block = '0;
        flag_block[`F_ILIM +: `RAIL_N] = s_q.sync[`S_ILIM +: `RAIL_N];
        flag_block[`F_TWARN] = s_q.sync[`S_TWARN];
        flag_block[`F_TSD]   = s_q.sync[`S_TSD];
        flag_block[`F_OVP]   = s_q.sync[`S_OVP];

        flag_mask = '0;
        flag_mask[`F_ILIM +: `RAIL_N] = rail_current_limit_mask;
        flag_mask[`F_PG +: `RAIL_N]   = rail_good_mask;
        flag_mask[`F_TWARN] = thermal_warn_mask;
        flag_mask[`F_GPIO]  = gpio_mask;
        flag_mask[`F_SYNC]  = sync_clk_mask;
        flag_mask[`F_ILOAD] = load_ready_mask;
        flag_mask[`F_RESET] = reset_flag_mask;

        // Masked flags still latch; unmaskable ones ignore the mask
        s_d.irq_n = ~|(flags & ~(flag_mask & `FLAG_MASKABLE));

        for (int i = 0; i < `RAIL_N; i++) begin
            s_d.summary[i] = flags[`F_ILIM + i] | flags[`F_SC + i] | flags[`F_PG + i];
        end

        // Protection shutdowns held until the flag is cleared
        s_d.rail_off = flags[`F_SC +: `RAIL_N]
                     | {`RAIL_N{flags[`F_TSD] | flags[`F_OVP]}};
        s_d.all_off  = flags[`F_TSD] | flags[`F_OVP]
                     | s_q.sync[`S_TSD] | s_q.sync[`S_OVP];
        s_d.gpio_low = s_d.all_off;

        // ----------------------------------------------------------------
        // Power-ok combination
        // ----------------------------------------------------------------
        for (int i = 0; i < `RAIL_N; i++) begin
            contrib[i] = rail_contrib(rail_monitor_select[i],
                                      flags[`F_SC + i] | flags[`F_TSD] | flags[`F_OVP],
                                      en[i], s_q.sync[`S_RAMP + i],
                                      volt_ok[i], ilim_f[i]);
        end

        // Fault source: set wins over the read-clear
        s_d.flt = ~contrib | (s_q.flt & ~({`RAIL_N{fault_source_read}} & contrib));
        if (soft_rst) begin
            s_d.flt = '0;
        end

        pg_active = (&contrib)
                  & ~(sticky_fault_hold_enable & |s_q.flt);
        pg_level  = power_ok_polarity ? pg_active : ~pg_active;

        // Open drain only pulls low; high level is released
        if (power_ok_open_drain) begin
            s_d.pwr_out  = 1'b0;
            s_d.pwr_oe_n = pg_level;
        end else begin
            s_d.pwr_out  = pg_level;
            s_d.pwr_oe_n = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q          <= '0;
            s_q.irq_n    <= 1'b1;
            s_q.pwr_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign irq_n_out                = s_q.irq_n;
    assign event_flags              = flags;
    assign rail_event_summary_flag  = s_q.summary;
    assign rail_current_limit_live  = s_q.sync[`S_ILIM +: `RAIL_N];
    assign rail_good_live           = s_q.good_prev;
    assign thermal_warn_live        = s_q.sync[`S_TWARN];
    assign thermal_shutdown_live    = s_q.sync[`S_TSD];
    assign supply_overvoltage_live  = s_q.sync[`S_OVP];
    assign gpio_in_level            = s_q.sync[`S_GPIO +: `GPIO_N];
    assign sync_clk_live            = s_q.sync[`S_CLKP];
    assign monitor_fault_source_reg = s_q.flt;
    assign rail_disable             = s_q.rail_off;
    assign all_rails_disable        = s_q.all_off;
    assign gpio_force_low           = s_q.gpio_low;
    assign power_ok_output          = s_q.pwr_out;
    assign power_ok_oe_n            = s_q.pwr_oe_n;
endmodule

/* rtl/fault_irq_pkg.sv */
package fault_irq_pkg;
`include "fault_irq_regs.svh"

    typedef logic [1:0] monitor_sel_t;

    typedef struct packed {
        logic [`CNT_W-1:0] cnt;
        logic              out;
    } deb_state_t;

    typedef struct packed {
        logic [`FLAG_W-1:0] flags;
    } flag_state_t;

    typedef struct packed {
        logic [`SYNC_W-1:0] meta;
        logic [`SYNC_W-1:0] sync;
        logic [`SYNC_W-1:0] prev;
        logic [`RAIL_N-1:0] ilim_prev;
        logic [`RAIL_N-1:0] sc_prev;
        logic [`RAIL_N-1:0] good_prev;
        logic [`RAIL_N-1:0] flt;
        logic [`RAIL_N-1:0] summary;
        logic [`RAIL_N-1:0] rail_off;
        logic               all_off;
        logic               gpio_low;
        logic               irq_n;
        logic               pwr_out;
        logic               pwr_oe_n;
    } main_state_t;
endpackage

/* rtl/fault_irq_regs.svh */
`ifndef FAULT_IRQ_REGS_SVH
`define FAULT_IRQ_REGS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define RAIL_N            4
`define GPIO_N            2
`define CNT_W             16

// ----------------------------------------------------------------
// Timing, in ns, and derived cycle counts (least times round up)
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     20
`define ILIM_DEB_NS       20000
`define SC_DEB_NS         1000000
`define PG_INVALID_NS     7000
`define PG_VALID_SHORT_NS 7000
`define PG_VALID_LONG_NS  20000
`define CYC_UP(ns)        (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ILIM_DEB_CYC      16'(`CYC_UP(`ILIM_DEB_NS))
`define SC_DEB_CYC        `CYC_UP(`SC_DEB_NS)
`define PG_INVALID_CYC    16'(`CYC_UP(`PG_INVALID_NS))
`define PG_VSHORT_CYC     16'(`CYC_UP(`PG_VALID_SHORT_NS))
`define PG_VLONG_CYC      16'(`CYC_UP(`PG_VALID_LONG_NS))
`define ONE_CYC           16'h0001

// ----------------------------------------------------------------
// Event flag vector layout
// ----------------------------------------------------------------
`define F_ILIM            0
`define F_SC              4
`define F_PG              8
`define F_TWARN           12
`define F_TSD             13
`define F_OVP             14
`define F_GPIO            15
`define F_SYNC            16
`define F_ILOAD           17
`define F_RESET           18
`define FLAG_W            19
`define FLAG_RST          19'h40000
`define FLAG_MASKABLE     19'h79f0f

// ----------------------------------------------------------------
// Synchronised input vector layout
// ----------------------------------------------------------------
`define S_ILIM            0
`define S_BELOW           4
`define S_UV              8
`define S_OV              12
`define S_EN              16
`define S_RAMP            20
`define S_TWARN           24
`define S_TSD             25
`define S_OVP             26
`define S_GPIO            27
`define S_CLKP            29
`define S_ILOAD           30
`define S_EXTRST          31
`define S_LOCK            32
`define SYNC_W            33

// ----------------------------------------------------------------
// Monitor selector codes
// ----------------------------------------------------------------
`define SEL_NONE          2'h0
`define SEL_VOLT          2'h1

`endif

/* rtl/level_debouncer.sv */
`timescale 1ns/1ps
`include "fault_irq_regs.svh"
// Output follows the input once it has held its new level for the given count.
module level_debouncer (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              qual,
    input  wire logic              level_in,
    input  wire logic [`CNT_W-1:0] rise_len,
    input  wire logic [`CNT_W-1:0] fall_len,
    output logic                   level_out
);
    import fault_irq_pkg::*;

    deb_state_t s_q;
    deb_state_t s_d;

    always_comb begin
        logic [`CNT_W-1:0] len;
        len = s_q.out ? fall_len : rise_len;
        s_d = s_q;
        if (!qual) begin
            // Disqualified input restarts the whole qualification time
            s_d.cnt = '0;
            s_d.out = 1'b0;
        end else if (level_in == s_q.out) begin
            s_d.cnt = '0;
        end else if (s_q.cnt + `ONE_CYC >= len) begin
            s_d.cnt = '0;
            s_d.out = level_in;
        end else begin
            s_d.cnt = s_q.cnt + `ONE_CYC;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.out;
endmodule

/* rtl/sticky_flag_bank.sv */
`timescale 1ns/1ps
`include "fault_irq_regs.svh"
// Sticky write-1-to-clear flags; a set always beats a clear in the same cycle.
module sticky_flag_bank (
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    input  wire logic               soft_rst,
    input  wire logic [`FLAG_W-1:0] set_evt,
    input  wire logic [`FLAG_W-1:0] clr_w1c,
    input  wire logic [`FLAG_W-1:0] clr_block,
    output logic      [`FLAG_W-1:0] flags
);
    import fault_irq_pkg::*;

    flag_state_t s_q;
    flag_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (soft_rst) begin
            s_d.flags = `FLAG_RST;
        end else begin
            // Clear refused while the cause is still present
            s_d.flags = set_evt | (s_q.flags & ~(clr_w1c & ~clr_block));
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.flags <= `FLAG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags = s_q.flags;
endmodule
